// >>> hw/direct_command_pkg.sv
// Constants, encodings and register map of the direct command decoder
package direct_command_pkg;
    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam logic [ADDR_W-1:0] REG_OPCTL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [REG_W-1:0] OPCTL_RESET = 8'h00;
    localparam logic [REG_W-1:0] CONFIG_RESET = 8'h00;
    localparam int OPC_EN_BIT = 7;
    localparam int OPC_RX_BIT = 6;
    localparam int OPC_TX_BIT = 3;
    localparam int CFG_REGS_BIT = 0;
    localparam int CFG_NRT_EMV_BIT = 1;
    localparam int CFG_AUTO_RESP_BIT = 2;
    localparam int CFG_GAIN_LSB = 4;
    localparam int GAIN_W = 4;
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_TEST_BIT = 1;
    localparam int STS_CODE_LSB = 8;
    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
    localparam logic [7:0] CMD_CLEAR_A = 8'hC2;
    localparam logic [7:0] CMD_CLEAR_B = 8'hC3;
    localparam logic [7:0] CMD_TX_CRC = 8'hC4;
    localparam logic [7:0] CMD_TX_NOCRC = 8'hC5;
    localparam logic [7:0] CMD_TX_REQA = 8'hC6;
    localparam logic [7:0] CMD_TX_WUPA = 8'hC7;
    localparam logic [7:0] CMD_RESET_GAIN = 8'hD5;
    localparam logic [7:0] CMD_ADJ_REG = 8'hD6;
    localparam logic [7:0] CMD_CAL_MOD = 8'hD7;
    localparam logic [7:0] CMD_CAL_ANT = 8'hD8;
    localparam logic [7:0] CMD_MEAS_PHASE = 8'hD9;
    localparam logic [7:0] CMD_CLR_RSSI = 8'hDA;
    localparam logic [7:0] CMD_CLR_TEST = 8'hFA;
    localparam logic [7:0] CMD_TEST_ACC = 8'hFC;
    // Transmit kind on tx_kind_o
    localparam logic [1:0] TX_KIND_CRC = 2'h0;
    localparam logic [1:0] TX_KIND_NOCRC = 2'h1;
    localparam logic [1:0] TX_KIND_REQA = 2'h2;
    localparam logic [1:0] TX_KIND_WUPA = 2'h3;
    // Sequencer states, Gray along idle, busy, done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b11
    } seq_state_t;
endpackage

// >>> hw/direct_command_decoder.sv
// Direct command decoder with its control registers and embedded checks
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module direct_command_decoder (
    input wire logic clock_i, // 25 MHz clock
    input wire logic arst_n_i, // Power-up reset, async
    input wire logic [direct_command_pkg::ADDR_W-1:0] addr_i, // Register address
    input wire logic [direct_command_pkg::DATA_W-1:0] wdata_i, // Write data
    input wire logic we_i, // Write strobe
    input wire logic re_i, // Read strobe
    output logic [direct_command_pkg::DATA_W-1:0] rdata_o, // Read data, next cycle
    input wire logic cmd_valid_i, // Command byte strobe
    input wire logic [7:0] cmd_code_i, // Command code
    input wire logic cmd_chained_i, // Byte follows another in one frame
    input wire logic xtal_stable_i, // Oscillator frequency stable
    input wire logic seq_done_i, // Analog sequence finished
    output logic gain_reset_o, // Drop squelch, load manual gain
    output logic [direct_command_pkg::GAIN_W-1:0] manual_gain_o, // Manual gain
    output logic regulator_adjust_o, // Start regulator adjust
    output logic mod_depth_cal_o, // Start modulation calibration
    output logic antenna_cal_o, // Start antenna trim
    output logic phase_meas_o, // Start phase measurement
    output logic rssi_clear_o, // Clear and restart signal strength
    output logic test_regs_clear_o, // Clear test registers
    output logic test_write_en_o, // Test registers writable
    output logic soft_default_o, // Return registers to power-up values
    output logic cal_results_clear_o, // Drop calibration results
    output logic fifo_clear_o, // Empty FIFO
    output logic fifo_status_clear_o, // Reset FIFO status
    output logic activity_abort_o, // Abort transmit or receive
    output logic timers_stop_o, // Stop timers except wake-up
    output logic nrt_stop_o, // Stop no-response timer
    output logic ca_timer_stop_o, // Stop collision avoidance timer
    output logic coll_irq_clear_o, // Reset collision and interrupt regs
    output logic tx_start_o, // Start transmission
    output logic [1:0] tx_kind_o, // Kind of transmission
    output logic cmd_irq_o, // Command completion interrupt
    output logic chip_en_o, // Operation control en
    output logic rx_en_o, // Operation control rx_en
    output logic tx_en_o // Operation control tx_en
);
    import direct_command_pkg::*;

    // ****************************************
    // Registers and state
    // ****************************************
    logic [REG_W-1:0] opctl;
    logic [REG_W-1:0] config_reg;
    logic [7:0] last_code;
    logic test_armed;
    seq_state_t state;
    seq_state_t next_state;

    // ****************************************
    // Decode
    // ****************************************
    wire en = opctl[OPC_EN_BIT];
    wire tx_en = opctl[OPC_TX_BIT];
    wire reg_s = config_reg[CFG_REGS_BIT];
    wire nrt_emv = config_reg[CFG_NRT_EMV_BIT];
    wire auto_response_bit = config_reg[CFG_AUTO_RESP_BIT];
    wire idle = (state == ST_IDLE);
    wire solo = !cmd_chained_i;
    wire is_default = cmd_valid_i && (cmd_code_i == CMD_SET_DEFAULT);
    wire is_clear = cmd_valid_i
        && (cmd_code_i == CMD_CLEAR_A || cmd_code_i == CMD_CLEAR_B);
    wire is_tx = cmd_valid_i && (cmd_code_i >= CMD_TX_CRC)
        && (cmd_code_i <= CMD_TX_WUPA);
    wire is_gain = cmd_valid_i && (cmd_code_i == CMD_RESET_GAIN);
    wire is_reg = cmd_valid_i && (cmd_code_i == CMD_ADJ_REG);
    wire is_mod = cmd_valid_i && (cmd_code_i == CMD_CAL_MOD);
    wire is_ant = cmd_valid_i && (cmd_code_i == CMD_CAL_ANT);
    wire is_phase = cmd_valid_i && (cmd_code_i == CMD_MEAS_PHASE);
    wire is_rssi = cmd_valid_i && (cmd_code_i == CMD_CLR_RSSI);
    wire is_tclr = cmd_valid_i && (cmd_code_i == CMD_CLR_TEST);
    wire is_tacc = cmd_valid_i && (cmd_code_i == CMD_TEST_ACC);

    // Acceptance by mode bits, chaining and sequencer state
    wire acc_default = is_default && solo;
    wire acc_clear = is_clear && en && xtal_stable_i && idle;
    wire acc_tx = is_tx && en && tx_en && idle;
    wire acc_gain = is_gain && en && solo && idle;
    wire acc_reg = is_reg && en && !reg_s && solo && idle;
    wire acc_mod = is_mod && en && solo && idle;
    wire acc_ant = is_ant && en && solo && idle;
    wire acc_phase = is_phase && en && solo && idle;
    wire acc_rssi = is_rssi && en && idle;
    wire acc_tacc = is_tacc;
    wire acc_tclr = is_tclr && cmd_chained_i && test_armed;
    wire acc_long = acc_reg || acc_mod || acc_ant || acc_phase;
    wire accepted = acc_default || acc_clear || acc_tx || acc_gain || acc_long
        || acc_rssi || acc_tacc || acc_tclr;

    wire [1:0] tx_kind_sel = cmd_code_i[1:0] == TX_KIND_CRC[1:0] ? TX_KIND_CRC
        : cmd_code_i[1:0] == TX_KIND_NOCRC[1:0] ? TX_KIND_NOCRC
        : cmd_code_i[1:0] == TX_KIND_REQA[1:0] ? TX_KIND_REQA : TX_KIND_WUPA;

    // Register access decode
    wire wr_opctl = we_i && (addr_i == REG_OPCTL);
    wire wr_config = we_i && (addr_i == REG_CONFIG);
    wire [DATA_W-1:0] status_word = {{(DATA_W - STS_CODE_LSB - 8){1'b0}}, last_code,
        {(STS_CODE_LSB - 2){1'b0}}, test_write_en_o, !idle};
    wire [DATA_W-1:0] rd_word = (addr_i == REG_OPCTL) ? {{(DATA_W - REG_W){1'b0}}, opctl}
        : (addr_i == REG_CONFIG) ? {{(DATA_W - REG_W){1'b0}}, config_reg}
        : (addr_i == REG_STATUS) ? status_word : '0;

    // ****************************************
    // Sequencer for commands with completion interrupt
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (acc_long) begin
                    next_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (seq_done_i) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (acc_default) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Registers; operation control survives soft default
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opctl <= OPCTL_RESET;
        end else if (wr_opctl) begin
            opctl <= wdata_i[REG_W-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            config_reg <= CONFIG_RESET;
        end else if (acc_default) begin
            config_reg <= CONFIG_RESET;
        end else if (wr_config) begin
            config_reg <= wdata_i[REG_W-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_code <= 8'h00;
            test_armed <= 1'b0;
            test_write_en_o <= 1'b0;
        end else begin
            if (acc_default) begin
                last_code <= 8'h00;
            end else if (accepted) begin
                last_code <= cmd_code_i;
            end
            if (cmd_valid_i) begin
                test_armed <= acc_tacc;
            end
            if (acc_default) begin
                test_write_en_o <= 1'b0;
            end else if (acc_tacc) begin
                test_write_en_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= re_i ? rd_word : '0;
        end
    end

    // ****************************************
    // Command pulses
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gain_reset_o <= 1'b0;
            regulator_adjust_o <= 1'b0;
            mod_depth_cal_o <= 1'b0;
            antenna_cal_o <= 1'b0;
            phase_meas_o <= 1'b0;
            rssi_clear_o <= 1'b0;
            test_regs_clear_o <= 1'b0;
            tx_start_o <= 1'b0;
            tx_kind_o <= TX_KIND_CRC;
            cmd_irq_o <= 1'b0;
        end else begin
            gain_reset_o <= acc_gain;
            regulator_adjust_o <= acc_reg;
            mod_depth_cal_o <= acc_mod;
            antenna_cal_o <= acc_ant;
            phase_meas_o <= acc_phase;
            rssi_clear_o <= acc_rssi;
            test_regs_clear_o <= acc_tclr;
            tx_start_o <= acc_tx;
            if (acc_tx) begin
                tx_kind_o <= tx_kind_sel;
            end
            cmd_irq_o <= (state == ST_BUSY) && seq_done_i && !acc_default;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            soft_default_o <= 1'b0;
            cal_results_clear_o <= 1'b0;
            fifo_clear_o <= 1'b0;
            fifo_status_clear_o <= 1'b0;
            activity_abort_o <= 1'b0;
            timers_stop_o <= 1'b0;
            nrt_stop_o <= 1'b0;
            ca_timer_stop_o <= 1'b0;
            coll_irq_clear_o <= 1'b0;
        end else begin
            soft_default_o <= acc_default;
            cal_results_clear_o <= acc_default;
            fifo_clear_o <= acc_clear || (acc_default && en);
            fifo_status_clear_o <= acc_clear || (acc_default && en);
            activity_abort_o <= acc_clear || acc_default;
            timers_stop_o <= acc_clear || acc_default;
            nrt_stop_o <= (acc_clear && !nrt_emv) || acc_default;
            ca_timer_stop_o <= (acc_clear && !auto_response_bit) || acc_default;
            coll_irq_clear_o <= acc_clear || acc_default;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            manual_gain_o <= '0;
            chip_en_o <= 1'b0;
            rx_en_o <= 1'b0;
            tx_en_o <= 1'b0;
        end else begin
            manual_gain_o <= config_reg[CFG_GAIN_LSB +: GAIN_W];
            chip_en_o <= opctl[OPC_EN_BIT];
            rx_en_o <= opctl[OPC_RX_BIT];
            tx_en_o <= opctl[OPC_TX_BIT];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    property p_gain_reset;
        (cmd_valid_i && cmd_code_i == CMD_RESET_GAIN && en && !cmd_chained_i && idle)
            |=> gain_reset_o && !cmd_irq_o;
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("gain reset missed");

    property p_reg_refused;
        (cmd_valid_i && cmd_code_i == CMD_ADJ_REG && reg_s) |=> !regulator_adjust_o;
    endproperty
    a_reg_refused: assert property (p_reg_refused) else $error("regulator ran with reg_s");

    sequence s_cal_run;
        mod_depth_cal_o ##1 (!seq_done_i && !acc_default)[*2] ##1 seq_done_i && !acc_default;
    endsequence
    property p_cal_irq;
        s_cal_run |=> cmd_irq_o ##1 !cmd_irq_o;
    endproperty
    a_cal_irq: assert property (p_cal_irq) else $error("calibration interrupt wrong");

    property p_ant_chained;
        (cmd_valid_i && cmd_code_i == CMD_CAL_ANT && cmd_chained_i) |=> !antenna_cal_o;
    endproperty
    a_ant_chained: assert property (p_ant_chained) else $error("chained antenna trim");

    property p_phase_en;
        (cmd_valid_i && cmd_code_i == CMD_MEAS_PHASE && !en) |=> !phase_meas_o;
    endproperty
    a_phase_en: assert property (p_phase_en) else $error("phase ran without en");

    property p_rssi_chain;
        (cmd_valid_i && cmd_code_i == CMD_CLR_RSSI && en && idle) |=> rssi_clear_o;
    endproperty
    a_rssi_chain: assert property (p_rssi_chain) else $error("signal strength clear missed");

    sequence s_fcfa;
        (cmd_valid_i && cmd_code_i == CMD_TEST_ACC)
            ##1 (cmd_valid_i && cmd_code_i == CMD_CLR_TEST && cmd_chained_i);
    endsequence
    property p_fcfa;
        s_fcfa |=> test_regs_clear_o && test_write_en_o;
    endproperty
    a_fcfa: assert property (p_fcfa) else $error("test clear after access missed");

    property p_fa_alone;
        (cmd_valid_i && cmd_code_i == CMD_CLR_TEST && !test_armed) |=> !test_regs_clear_o;
    endproperty
    a_fa_alone: assert property (p_fa_alone) else $error("test clear without access");

    property p_tx_mode;
        (cmd_valid_i && is_tx && !tx_en) |=> !tx_start_o;
    endproperty
    a_tx_mode: assert property (p_tx_mode) else $error("transmit without tx_en");

    property p_default_opctl;
        (acc_default && !we_i) |=> $stable(opctl) && config_reg == CONFIG_RESET;
    endproperty
    a_default_opctl: assert property (p_default_opctl) else $error("default map wrong");

    property p_default_fifo;
        acc_default |=> cal_results_clear_o && (fifo_clear_o == $past(en)) && !cmd_irq_o;
    endproperty
    a_default_fifo: assert property (p_default_fifo) else $error("default effects wrong");

    property p_clear_timers;
        acc_clear |=> fifo_clear_o && coll_irq_clear_o && timers_stop_o
            && (nrt_stop_o != $past(nrt_emv)) && (ca_timer_stop_o != $past(auto_response_bit));
    endproperty
    a_clear_timers: assert property (p_clear_timers) else $error("clear effects wrong");

    property p_clear_xtal;
        (is_clear && !xtal_stable_i && !acc_default) |=> !fifo_clear_o;
    endproperty
    a_clear_xtal: assert property (p_clear_xtal) else $error("clear with unstable xtal");
endmodule

// >>> test/direct_command_host.sv
// Host controller and analog sequence model facing the command port
`timescale 1ns/100ps
module direct_command_host (
    input wire logic clock_i, // System clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic seq_start_i, // Any analog sequence started
    input wire logic [3:0] lat_i, // Cycles until sequence done
    output logic cmd_valid_o, // Command byte strobe
    output logic [7:0] cmd_code_o, // Command code
    output logic cmd_chained_o, // Byte chained to previous
    output logic seq_done_o // Analog sequence finished
);
    logic [3:0] cnt;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_chained_o = 1'b0;
    end
    // One byte per call; lines inverted once the byte is gone
    task automatic send(input logic [7:0] code, input logic chain);
        @(posedge clock_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        cmd_chained_o <= chain;
        @(posedge clock_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~code;
        cmd_chained_o <= ~chain;
    endtask
    // Two bytes on consecutive edges, the second one chained
    task automatic send_pair(input logic [7:0] code_a, input logic [7:0] code_b);
        @(posedge clock_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code_a;
        cmd_chained_o <= 1'b0;
        @(posedge clock_i);
        cmd_code_o <= code_b;
        cmd_chained_o <= 1'b1;
        @(posedge clock_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~code_b;
        cmd_chained_o <= 1'b0;
    endtask
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 4'h0;
            seq_done_o <= 1'b0;
        end else begin
            seq_done_o <= (cnt == 4'h1);
            cnt <= seq_start_i ? lat_i : ((cnt != 4'h0) ? cnt - 4'h1 : cnt);
        end
    end
endmodule

// >>> test/direct_command_decoder_tb.sv
// Self-checking bench for the direct command decoder
`timescale 1ns/100ps
module direct_command_decoder_tb;
    import direct_command_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic xtal_stable_i = 1'b0;
    logic [3:0] lat = 4'h2;
    logic [DATA_W-1:0] rdata_o;
    logic cmd_valid_i, cmd_chained_i, seq_done_i, gain_reset_o, regulator_adjust_o;
    logic mod_depth_cal_o, antenna_cal_o, phase_meas_o, rssi_clear_o, test_regs_clear_o;
    logic test_write_en_o, soft_default_o, cal_results_clear_o, fifo_clear_o;
    logic fifo_status_clear_o, activity_abort_o, timers_stop_o, nrt_stop_o;
    logic ca_timer_stop_o, coll_irq_clear_o, tx_start_o, cmd_irq_o, chip_en_o, rx_en_o, tx_en_o;
    logic [7:0] cmd_code_i;
    logic [GAIN_W-1:0] manual_gain_o;
    logic [1:0] tx_kind_o;
    logic [16:0] pulses;
    logic [7:0] off_codes [6] = '{8'hC2, 8'hC4, 8'hD5, 8'hD7, 8'hD9, 8'hDA};
    logic [7:0] bad_codes [4] = '{8'hD2, 8'hE0, 8'hF0, 8'hFF};
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    assign pulses = {gain_reset_o, regulator_adjust_o, mod_depth_cal_o, antenna_cal_o,
        phase_meas_o, rssi_clear_o, test_regs_clear_o, soft_default_o, cal_results_clear_o,
        fifo_clear_o, fifo_status_clear_o, activity_abort_o, timers_stop_o, nrt_stop_o,
        ca_timer_stop_o, coll_irq_clear_o, tx_start_o};
    direct_command_decoder direct_command_decoder_inst (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .cmd_valid_i(cmd_valid_i),
        .cmd_code_i(cmd_code_i), .cmd_chained_i(cmd_chained_i),
        .xtal_stable_i(xtal_stable_i), .seq_done_i(seq_done_i),
        .gain_reset_o(gain_reset_o), .manual_gain_o(manual_gain_o),
        .regulator_adjust_o(regulator_adjust_o), .mod_depth_cal_o(mod_depth_cal_o),
        .antenna_cal_o(antenna_cal_o), .phase_meas_o(phase_meas_o),
        .rssi_clear_o(rssi_clear_o), .test_regs_clear_o(test_regs_clear_o),
        .test_write_en_o(test_write_en_o), .soft_default_o(soft_default_o),
        .cal_results_clear_o(cal_results_clear_o), .fifo_clear_o(fifo_clear_o),
        .fifo_status_clear_o(fifo_status_clear_o), .activity_abort_o(activity_abort_o),
        .timers_stop_o(timers_stop_o), .nrt_stop_o(nrt_stop_o),
        .ca_timer_stop_o(ca_timer_stop_o), .coll_irq_clear_o(coll_irq_clear_o),
        .tx_start_o(tx_start_o), .tx_kind_o(tx_kind_o), .cmd_irq_o(cmd_irq_o),
        .chip_en_o(chip_en_o), .rx_en_o(rx_en_o), .tx_en_o(tx_en_o));
    direct_command_host direct_command_host_inst (
        .clock_i(clock_i), .arst_n_i(arst_n_i),
        .seq_start_i(regulator_adjust_o | mod_depth_cal_o | antenna_cal_o | phase_meas_o),
        .lat_i(lat), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
        .cmd_chained_o(cmd_chained_i), .seq_done_o(seq_done_i));
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            error_cnt++;
            results();
        end
    end
    // ****************************************
    // Bus, command and compare tasks
    // ****************************************
    task automatic chk_p(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t pulses %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= {24'h00_0000, d};
        @(posedge clock_i);
        we_i <= 1'b0;
        wdata_i <= ~wdata_i;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        re_i <= 1'b0;
        #1;
        chk_w(rdata_o, exp);
    endtask
    task automatic cmd(input logic [7:0] c, input logic ch, input logic [16:0] ep,
        input logic ei);
        logic seen;
        seen = 1'b0;
        direct_command_host_inst.send(c, ch);
        #1;
        chk_p(pulses, ep);
        repeat (12) begin
            @(posedge clock_i);
            #1;
            seen = seen | (cmd_irq_o === 1'b1);
        end
        chk_b(seen, ei);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1'b1;
        rd(REG_OPCTL, 32'h0000_0000);
        rd(REG_CONFIG, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0000);
        rd(8'h0C, 32'h0000_0000);
        foreach (off_codes[i]) cmd(off_codes[i], 1'b0, 17'h0_0000, 1'b0);
        cmd(CMD_SET_DEFAULT, 1'b0, 17'h0_033E, 1'b0);
        cmd(CMD_CLR_TEST, 1'b1, 17'h0_0000, 1'b0);
        cmd(CMD_TEST_ACC, 1'b0, 17'h0_0000, 1'b0);
        rd(REG_STATUS, 32'h0000_FC02);
        cmd(CMD_CLR_TEST, 1'b0, 17'h0_0000, 1'b0);
        cmd(CMD_TEST_ACC, 1'b1, 17'h0_0000, 1'b0);
        chk_b(test_write_en_o, 1'b1);
        cmd(CMD_CLR_TEST, 1'b1, 17'h0_0400, 1'b0);
        direct_command_host_inst.send_pair(CMD_TEST_ACC, CMD_CLR_TEST);
        #1;
        chk_p(pulses, 17'h0_0400);
        foreach (bad_codes[i]) cmd(bad_codes[i], 1'b0, 17'h0_0000, 1'b0);
        wr(REG_OPCTL, 8'h80);
        wr(REG_CONFIG, 8'h51);
        repeat (2) @(posedge clock_i);
        #1;
        chk_w(32'(manual_gain_o), 32'h0000_0005);
        cmd(CMD_RESET_GAIN, 1'b1, 17'h0_0000, 1'b0);
        cmd(CMD_RESET_GAIN, 1'b0, 17'h1_0000, 1'b0);
        cmd(CMD_ADJ_REG, 1'b0, 17'h0_0000, 1'b0);
        wr(REG_CONFIG, 8'h00);
        for (int i = 0; i < 4; i++) begin
            cmd(CMD_ADJ_REG + 8'(i), 1'b1, 17'h0_0000, 1'b0);
            cmd(CMD_ADJ_REG + 8'(i), 1'b0, 17'h0_8000 >> i, 1'b1);
        end
        cmd(CMD_CLR_RSSI, 1'b1, 17'h0_0800, 1'b0);
        cmd(CMD_CLEAR_A, 1'b0, 17'h0_0000, 1'b0);
        @(posedge clock_i);
        xtal_stable_i <= 1'b1;
        cmd(CMD_CLEAR_A, 1'b0, 17'h0_00FE, 1'b0);
        wr(REG_CONFIG, 8'h06);
        cmd(CMD_CLEAR_B, 1'b1, 17'h0_00F2, 1'b0);
        cmd(CMD_TX_CRC, 1'b0, 17'h0_0000, 1'b0);
        wr(REG_OPCTL, 8'hC8);
        repeat (2) @(posedge clock_i);
        #1;
        chk_w(32'({chip_en_o, rx_en_o, tx_en_o}), 32'h0000_0007);
        for (int i = 0; i < 4; i++) begin
            if (i < 2) begin
                cmd(CMD_CLEAR_A, 1'b1, 17'h0_00F2, 1'b0);
            end
            cmd(CMD_TX_CRC + 8'(i), 1'b1, 17'h0_0001, 1'b0);
            chk_w(32'(tx_kind_o), 32'(i));
        end
        lat <= 4'h8;
        direct_command_host_inst.send(CMD_CAL_MOD, 1'b0);
        cmd(CMD_CLR_RSSI, 1'b1, 17'h0_0000, 1'b1);
        direct_command_host_inst.send(CMD_CAL_ANT, 1'b0);
        cmd(CMD_SET_DEFAULT, 1'b0, 17'h0_03FE, 1'b0);
        rd(REG_CONFIG, 32'h0000_0000);
        rd(REG_OPCTL, 32'h0000_00C8);
        chk_b(test_write_en_o, 1'b0);
        cmd(CMD_SET_DEFAULT, 1'b1, 17'h0_0000, 1'b0);
        results();
    end
endmodule
